//--- perf_counter_pkg.sv
// Constants shared by the event counter block and its counter slices
package perf_counter_pkg;
  localparam int          CNT_W        = 32;   // Width of each event counter
  localparam int          INC_W        = 4;    // Width of a per-cycle increment
  localparam int          EV_W         = 4;    // Event field width inside one counter
  localparam int          NUM_CNT      = 2;    // Number of event counters
  // Special register select codes
  localparam logic [1:0]  SEL_CTL0     = 2'h0;
  localparam logic [1:0]  SEL_CNT0     = 2'h1;
  localparam logic [1:0]  SEL_CTL1     = 2'h2;
  localparam logic [1:0]  SEL_CNT1     = 2'h3;
  // Control register fields
  localparam int          CTL_EV_LSB   = 0;    // Event code bits [3:0]
  localparam int          CTL_BANK_BIT = 4;    // Code bit 4 picks the counter
  localparam int          CTL_TRAP_BIT = 5;    // Overflow trap enable
  localparam int          CTL_OVF_BIT  = 6;    // Sticky overflow, read only
  localparam logic [3:0]  CTL_EV_RST   = 4'h0;
  localparam logic        CTL_TRAP_RST = 1'b0;
  localparam logic [31:0] CNT_RST      = 32'h0000_0000;
  // Event codes, local to a counter (global code = bank * 16 + local)
  localparam logic [3:0]  EV0_CYCLES   = 4'h0;
  localparam logic [3:0]  EV0_ISSUED   = 4'h1;
  localparam logic [3:0]  EV0_LD_ISS   = 4'h2;
  localparam logic [3:0]  EV0_ST_ISS   = 4'h3;
  localparam logic [3:0]  EV0_DONE     = 4'he;
  localparam logic [3:0]  EV0_GRAD     = 4'hf;
  localparam logic [3:0]  EV1_CYCLES   = 4'h0;
  localparam logic [3:0]  EV1_GRAD     = 4'h1;
  localparam logic [3:0]  EV1_GRAD_LD  = 4'h2;
  localparam logic [3:0]  EV1_GRAD_ST  = 4'h3;
  localparam logic [3:0]  EV1_GRAD_FP  = 4'h5;
  // Miss table retry spacing while the table is full, in cycles
  localparam logic [2:0]  MHT_GAP      = 3'h4;
endpackage

//--- perf_cnt_if.sv
// Carrier between the top block and one counter slice
`timescale 1ns/1ns
interface perf_cnt_if;
  import perf_counter_pkg::*;
  logic             wr_ctl;
  logic             wr_cnt;
  logic [31:0]      wdata;
  logic [INC_W-1:0] inc;
  logic [EV_W-1:0]  ev;
  logic             trap_en;
  logic [CNT_W-1:0] count;
  logic             ovf;
  logic             carry;
  modport top   (output wr_ctl, wr_cnt, wdata, inc, input ev, trap_en, count, ovf, carry);
  modport slice (input wr_ctl, wr_cnt, wdata, inc, output ev, trap_en, count, ovf, carry);
endinterface

//--- perf_counter_slice.sv
// One event counter with its control fields and sticky overflow
`timescale 1ns/1ns
module perf_counter_slice
  import perf_counter_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  perf_cnt_if.slice p
);
  logic [CNT_W:0] sum;

  // Add the multi-bit increment with carry out
  assign sum     = {1'b0, p.count} + {{(CNT_W+1-INC_W){1'b0}}, p.inc}; // RULE_16
  assign p.carry = sum[CNT_W] & ~p.wr_cnt;

  // Counter preload or accumulate, wrapping at the top
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p.count <= CNT_RST;
    end else if (p.wr_cnt) begin
      p.count <= p.wdata[CNT_W-1:0]; // RULE_17
    end else begin
      p.count <= sum[CNT_W-1:0]; // RULE_16
    end
  end

  // Control fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p.ev      <= CTL_EV_RST;
      p.trap_en <= CTL_TRAP_RST;
    end else if (p.wr_ctl) begin
      p.ev      <= p.wdata[CTL_EV_LSB +: EV_W]; // RULE_17
      p.trap_en <= p.wdata[CTL_TRAP_BIT];
    end
  end

  // Sticky overflow; a preload clears it and masks any carry in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p.ovf <= 1'b0;
    end else begin
      p.ovf <= p.carry | (p.ovf & ~p.wr_cnt); // RULE_02
    end
  end

  AST_WRAP_OVF: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_16
    !$past(p.wr_cnt) && (p.count < $past(p.count)) |-> p.ovf)
    else $error("counter wrapped without overflow flag");
endmodule // perf_counter_slice

//--- cpu_perf_event_counters.sv
// Two event counters fed by pipeline event sources, with overflow trap
// Behaviour
// RULE_01: two 32-bit counters, sixteen events each
// RULE_02: enabled overflow raises trap after N events
// RULE_03: codes 0-15 counter zero, 16-31 counter one
// RULE_04: cycles event counts every clock
// RULE_05: issued event sums done, FP, load/store
// RULE_06: failed tag check reissues and recounts
// RULE_07: full miss table: reissue every four cycles
// RULE_08: event 2 counts new loads, prior cycle
// RULE_09: event 3 counts new stores, prior cycle
// RULE_10: event 14 counts cycle after any done
// RULE_11: graduated counts exclude discarded instructions
// RULE_12: at most one load/store per cycle
// RULE_13: reissue counted issued, graduated once
// RULE_14: graduated adds prior count, muldiv counts two
// RULE_15: graduated loads add up to four
// RULE_16: multi-bit increment, wrap, carry flags overflow
// RULE_17: software reads, preloads, configures counters
`timescale 1ns/1ns
module cpu_perf_event_counters
  import perf_counter_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Special register port
  input  wire logic        sr_wr,
  input  wire logic        sr_rd,
  input  wire logic [1:0]  sr_sel,
  input  wire logic [31:0] sr_wdata,
  output logic      [31:0] sr_rdata_r,
  // Execution unit done marks
  input  wire logic        integer_exec_unit_a_done,
  input  wire logic        integer_exec_unit_b_done,
  input  wire logic        float_exec_unit_a_done,
  input  wire logic        float_exec_unit_b_done,
  input  wire logic [1:0]  fp_issue_cnt,
  // Load/store path
  input  wire logic        ls_issue,
  input  wire logic        ls_is_store,
  input  wire logic        ls_tagchk,
  input  wire logic        tag_bank_busy,
  input  wire logic        refill_bank_start,
  input  wire logic        ls_mht_wait,
  input  wire logic        mht_full,
  output logic             ls_reissue_r,
  // Graduation
  input  wire logic [2:0]  grad_insn_cnt,
  input  wire logic [2:0]  grad_muldiv_cnt,
  input  wire logic [2:0]  grad_load_cnt,
  input  wire logic        grad_store,
  input  wire logic [2:0]  grad_fp_cnt,
  // Other single-bit event pulses by global code
  input  wire logic [31:0] misc_event,
  output logic             trap_r
);
  perf_cnt_if pc[NUM_CNT] ();

  logic             refill_prev_r;
  logic             tag_fail;
  logic             mht_grant;
  logic [2:0]       gap_r;
  logic             ls_any_r;
  logic             ld_new_r;
  logic             st_new_r;
  logic             done_any_r;
  logic [INC_W-1:0] grad_r;
  logic [2:0]       grad_ld_r;
  logic             grad_st_r;
  logic [2:0]       grad_fp_r;
  logic [31:0]      misc_r;
  logic [1:0]       int_done_cnt;
  logic [INC_W-1:0] issued_sum;
  logic [INC_W-1:0] inc_tab0 [16];
  logic [INC_W-1:0] inc_tab1 [16];

  function automatic logic [INC_W-1:0] widen3(input logic [2:0] v);
    widen3 = {{(INC_W-3){1'b0}}, v};
  endfunction

  function automatic logic [INC_W-1:0] widen1(input logic v);
    widen1 = {{(INC_W-1){1'b0}}, v};
  endfunction

  // Tag check fails on a busy bank or a refill begun last cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refill_prev_r <= 1'b0;
    end else begin
      refill_prev_r <= refill_bank_start; // RULE_06
    end
  end
  assign tag_fail = ls_tagchk & (tag_bank_busy | refill_prev_r); // RULE_06

  // Miss table retry throttle
  assign mht_grant = ls_mht_wait & (~mht_full | (gap_r == 3'h0)); // RULE_07
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 3'h0;
    end else if (mht_grant && mht_full) begin
      gap_r <= MHT_GAP - 3'h1; // RULE_07
    end else if (gap_r != 3'h0) begin
      gap_r <= gap_r - 3'h1;
    end
  end

  // Reissue strobe back to the load/store path
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_reissue_r <= 1'b0;
    end else begin
      ls_reissue_r <= tag_fail | mht_grant; // RULE_06 RULE_07
    end
  end

  // Previous-cycle event samples
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ls_any_r   <= 1'b0;
      ld_new_r   <= 1'b0;
      st_new_r   <= 1'b0;
      done_any_r <= 1'b0;
      grad_r     <= '0;
      grad_ld_r  <= 3'h0;
      grad_st_r  <= 1'b0;
      grad_fp_r  <= 3'h0;
      misc_r     <= 32'h0000_0000;
    end else begin
      ls_any_r   <= ls_issue | ls_reissue_r;         // RULE_12 RULE_13
      ld_new_r   <= ls_issue & ~ls_is_store;         // RULE_08
      st_new_r   <= ls_issue & ls_is_store;          // RULE_09
      done_any_r <= integer_exec_unit_a_done | integer_exec_unit_b_done
                  | float_exec_unit_a_done | float_exec_unit_b_done; // RULE_10
      grad_r     <= widen3(grad_insn_cnt) + widen3(grad_muldiv_cnt); // RULE_14 RULE_11
      grad_ld_r  <= grad_load_cnt;                   // RULE_15
      grad_st_r  <= grad_store;                      // RULE_13
      grad_fp_r  <= grad_fp_cnt;
      misc_r     <= misc_event;
    end
  end

  // Issued sum: integer done, FP issued, load/store of last cycle
  assign int_done_cnt = {1'b0, integer_exec_unit_a_done} + {1'b0, integer_exec_unit_b_done};
  assign issued_sum   = {2'b00, int_done_cnt} + {2'b00, fp_issue_cnt}
                      + widen1(ls_any_r); // RULE_05 RULE_06

  // Per-counter event tables
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      inc_tab0[i] = widen1(misc_r[i]);
      inc_tab1[i] = widen1(misc_r[16+i]);
    end
    inc_tab0[EV0_CYCLES]  = widen1(1'b1);     // RULE_04
    inc_tab0[EV0_ISSUED]  = issued_sum;       // RULE_05
    inc_tab0[EV0_LD_ISS]  = widen1(ld_new_r); // RULE_08
    inc_tab0[EV0_ST_ISS]  = widen1(st_new_r); // RULE_09
    inc_tab0[EV0_DONE]    = widen1(done_any_r); // RULE_10
    inc_tab0[EV0_GRAD]    = grad_r;           // RULE_14
    inc_tab1[EV1_CYCLES]  = widen1(1'b1);     // RULE_04
    inc_tab1[EV1_GRAD]    = grad_r;           // RULE_14
    inc_tab1[EV1_GRAD_LD] = widen3(grad_ld_r); // RULE_15
    inc_tab1[EV1_GRAD_ST] = widen1(grad_st_r);
    inc_tab1[EV1_GRAD_FP] = widen3(grad_fp_r);
  end

  // Counter slices and their write decode
  assign pc[0].wr_ctl = sr_wr & (sr_sel == SEL_CTL0) & ~sr_wdata[CTL_BANK_BIT]; // RULE_03
  assign pc[1].wr_ctl = sr_wr & (sr_sel == SEL_CTL1) & sr_wdata[CTL_BANK_BIT];  // RULE_03
  assign pc[0].wr_cnt = sr_wr & (sr_sel == SEL_CNT0); // RULE_17
  assign pc[1].wr_cnt = sr_wr & (sr_sel == SEL_CNT1); // RULE_17
  assign pc[0].inc    = inc_tab0[pc[0].ev]; // RULE_01
  assign pc[1].inc    = inc_tab1[pc[1].ev]; // RULE_01
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    assign pc[g].wdata = sr_wdata;
    perf_counter_slice u_slice (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .p       (pc[g])
    );
  end

  // Special register read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_rdata_r <= 32'h0000_0000;
    end else if (sr_rd) begin
      unique case (sr_sel)
        SEL_CTL0: sr_rdata_r <= {25'h0, pc[0].ovf, pc[0].trap_en, 1'b0, pc[0].ev}; // RULE_17
        SEL_CNT0: sr_rdata_r <= pc[0].count;
        SEL_CTL1: sr_rdata_r <= {25'h0, pc[1].ovf, pc[1].trap_en, 1'b1, pc[1].ev}; // RULE_03
        SEL_CNT1: sr_rdata_r <= pc[1].count;
      endcase
    end
  end

  // Overflow trap from either enabled counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_r <= 1'b0;
    end else begin
      trap_r <= (pc[0].ovf & pc[0].trap_en) | (pc[1].ovf & pc[1].trap_en); // RULE_02
    end
  end

  AST_CYCLES: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
    pc[0].ev == EV0_CYCLES && !pc[0].wr_cnt |=> pc[0].count == $past(pc[0].count) + 32'h1)
    else $error("cycles event did not add one");
  AST_TRAP: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_02
    (pc[0].carry && pc[0].trap_en && !pc[0].wr_ctl)
    || (pc[1].carry && pc[1].trap_en && !pc[1].wr_ctl) |=> ##1 trap_r)
    else $error("overflow did not raise trap");
  AST_ISSUE_SUM: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
    ls_issue && !integer_exec_unit_a_done && !integer_exec_unit_b_done ##1
    fp_issue_cnt == 2'h0 && !integer_exec_unit_a_done && !integer_exec_unit_b_done
    |-> issued_sum == 4'h1)
    else $error("issued sum wrong");
  AST_TAG_RETRY: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
    ls_tagchk && tag_bank_busy |=> ls_reissue_r ##1 ls_any_r)
    else $error("tag check failure not reissued and counted");
  AST_MHT_GAP: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
    mht_grant && mht_full |=> (!mht_grant || !mht_full) [*3])
    else $error("miss table retry faster than four cycles");
  AST_LOAD_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_08
    ls_reissue_r && !ls_issue |=> !ld_new_r && !st_new_r)
    else $error("reissue counted as new load or store");
  AST_STORE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_09
    ls_issue && ls_is_store |=> inc_tab0[EV0_ST_ISS] == 4'h1)
    else $error("store issue not counted");
  AST_DONE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_10
    float_exec_unit_b_done |=> inc_tab0[EV0_DONE] == 4'h1)
    else $error("done not counted next cycle");
  AST_GRAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_14
    grad_insn_cnt == 3'h3 && grad_muldiv_cnt == 3'h1 |=> grad_r == 4'h4)
    else $error("graduated weighting wrong");
  AST_RDATA: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_17
    sr_rd && sr_sel == SEL_CNT1 |=> sr_rdata_r == $past(pc[1].count))
    else $error("counter readback wrong");

  COV_TRAP:    cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(trap_r));
  COV_MHT:     cover property (@(posedge ref_clk) disable iff (!rst_n)
    mht_grant && mht_full ##4 mht_grant && mht_full);
  COV_PRELOAD: cover property (@(posedge ref_clk) disable iff (!rst_n)
    pc[0].wr_cnt ##[1:20] pc[0].carry);
endmodule // cpu_perf_event_counters

//--- pipe_event_model.sv
// Pipeline model issuing new loads and stores into the counter block
`timescale 1ns/1ns
module pipe_event_model
  import perf_counter_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ls_reissue_r,
  input  wire logic       go,
  input  wire logic [2:0] n_ops,
  input  wire logic       store_op,
  output logic            ls_issue,
  output logic            ls_is_store
);
  logic [2:0] left_r;
  // One new op per cycle at most, held off while the block reissues
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r      <= 3'h0;
      ls_issue    <= 1'b0;
      ls_is_store <= 1'b0;
    end else if (go) begin
      left_r   <= n_ops;
      ls_issue <= 1'b0;
    end else if (left_r != 3'h0 && !ls_reissue_r) begin
      ls_issue    <= 1'b1;
      ls_is_store <= store_op;
      left_r      <= left_r - 3'h1;
    end else begin
      ls_issue    <= 1'b0;
      ls_is_store <= ~ls_is_store; // Qualifier means nothing when idle
    end
  end
endmodule // pipe_event_model

//--- cpu_perf_event_counters_bench.sv
// Self-checking bench for the two event counters
`timescale 1ns/1ns
module cpu_perf_event_counters_bench;
  import perf_counter_pkg::*;
  logic        ref_clk, rst_n, sr_wr, sr_rd, ls_issue, ls_is_store, ls_tagchk;
  logic        integer_exec_unit_a_done, integer_exec_unit_b_done, go, store_op;
  logic        float_exec_unit_a_done, float_exec_unit_b_done, tag_bank_busy;
  logic        refill_bank_start, ls_mht_wait, mht_full, ls_reissue_r, grad_store, trap_r;
  logic [1:0]  sr_sel, fp_issue_cnt;
  logic [2:0]  grad_insn_cnt, grad_muldiv_cnt, grad_load_cnt, grad_fp_cnt, n_ops;
  logic [31:0] sr_wdata, sr_rdata_r, misc_event, v;
  int          bad_count, tests_run, cycles;

  cpu_perf_event_counters i_cpu_perf_event_counters (.ref_clk, .rst_n, .sr_wr, .sr_rd,
    .sr_sel, .sr_wdata, .sr_rdata_r, .integer_exec_unit_a_done, .integer_exec_unit_b_done,
    .float_exec_unit_a_done, .float_exec_unit_b_done, .fp_issue_cnt, .ls_issue,
    .ls_is_store, .ls_tagchk, .tag_bank_busy, .refill_bank_start, .ls_mht_wait, .mht_full,
    .ls_reissue_r, .grad_insn_cnt, .grad_muldiv_cnt, .grad_load_cnt, .grad_store,
    .grad_fp_cnt, .misc_event, .trap_r);
  pipe_event_model i_pipe_event_model (.ref_clk, .rst_n, .ls_reissue_r, .go, .n_ops,
    .store_op, .ls_issue, .ls_is_store);

  // Verdict and end of run
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Special register write, taken at the second edge
  task automatic wr(input logic [1:0] sel, input logic [31:0] d);
    @(posedge ref_clk);
    sr_wr <= 1'b1;
    sr_sel <= sel;
    sr_wdata <= d;
    @(posedge ref_clk);
    sr_wr <= 1'b0;
  endtask
  // Special register read, data one edge after it is taken
  task automatic rd(input logic [1:0] sel, output logic [31:0] d);
    @(posedge ref_clk);
    sr_rd <= 1'b1;
    sr_sel <= sel;
    @(posedge ref_clk);
    sr_rd <= 1'b0;
    @(posedge ref_clk);
    #1 d = sr_rdata_r;
  endtask
  // All pipeline event sources idle
  task automatic quiet();
    {integer_exec_unit_a_done, integer_exec_unit_b_done} <= 2'h0;
    {float_exec_unit_a_done, float_exec_unit_b_done} <= 2'h0;
    {ls_tagchk, tag_bank_busy, refill_bank_start, ls_mht_wait, mht_full} <= 5'h0;
    {fp_issue_cnt, grad_store, go, store_op} <= 5'h0;
    {grad_insn_cnt, grad_muldiv_cnt, grad_load_cnt, grad_fp_cnt, n_ops} <= 15'h0;
    misc_event <= 32'h0;
  endtask

  // Reset values and bank bit of each control register
  task automatic t_reset();
    chk("trap", 32'h0, {31'h0, trap_r});
    rd(SEL_CTL0, v); chk("ctl0", 32'h0, v);
    rd(SEL_CTL1, v); chk("ctl1", 32'h10, v);
  endtask
  // Cycles event counts each clock after a preload
  task automatic t_cycles();
    wr(SEL_CNT0, 32'h0);
    tick(5);
    rd(SEL_CNT0, v); chk("cnt0", 32'h6, v);
  endtask
  // Overflow N events after preload, with and without trap enable
  task automatic t_trap();
    wr(SEL_CTL0, 32'h20);
    wr(SEL_CNT0, 32'hffff_fffd);
    tick(3);
    #1 chk("trap", 32'h0, {31'h0, trap_r});
    tick(1);
    #1 chk("trap", 32'h1, {31'h0, trap_r});
    rd(SEL_CTL0, v); chk("ctl0", 32'h60, v);
    wr(SEL_CTL0, 32'h0);
    tick(1);
    #1 chk("trap", 32'h0, {31'h0, trap_r});
    wr(SEL_CNT0, 32'h0);
    wr(SEL_CNT1, 32'hffff_fffe);
    tick(4);
    #1 chk("trap", 32'h0, {31'h0, trap_r});
    rd(SEL_CTL1, v); chk("ctl1", 32'h50, v);
    rd(SEL_CNT1, v); chk("cnt1", 32'h6, v);
    wr(SEL_CNT1, 32'h0);
  endtask
  // Control writes naming the wrong counter are dropped
  task automatic t_refuse();
    wr(SEL_CTL0, 32'h3);
    wr(SEL_CTL0, 32'h11);
    rd(SEL_CTL0, v); chk("ctl0", 32'h3, v);
    wr(SEL_CTL1, 32'h2);
    rd(SEL_CTL1, v); chk("ctl1", 32'h10, v);
  endtask
  // Tag check failures from a busy bank or a fresh refill
  task automatic t_tag();
    @(posedge ref_clk) {ls_tagchk, tag_bank_busy} <= 2'h3;
    @(posedge ref_clk) quiet();
    #1 chk("reissue", 32'h1, {31'h0, ls_reissue_r});
    @(posedge ref_clk) refill_bank_start <= 1'b1;
    @(posedge ref_clk) {ls_tagchk, refill_bank_start} <= 2'h2;
    @(posedge ref_clk) quiet();
    #1 chk("reissue", 32'h1, {31'h0, ls_reissue_r});
    @(posedge ref_clk);
    #1 chk("reissue", 32'h0, {31'h0, ls_reissue_r});
  endtask
  // Full miss table grants one retry per four cycles
  task automatic t_mht();
    int n;
    n = 0;
    @(posedge ref_clk) {ls_mht_wait, mht_full} <= 2'h3;
    tick(2);
    repeat (12) begin
      @(posedge ref_clk);
      #1 if (ls_reissue_r === 1'b1) n++;
    end
    chk("retries", 32'h3, n);
    @(posedge ref_clk) quiet();
    tick(4);
  endtask
  // Program both counters, apply one event burst, read both totals
  task automatic t_events(input logic [31:0] c0, c1, input int mode, input logic [2:0] n,
                          input logic st, input logic [31:0] e0, e1);
    wr(SEL_CTL0, c0);
    wr(SEL_CTL1, c1);
    wr(SEL_CNT0, 32'h0);
    wr(SEL_CNT1, 32'h0);
    @(posedge ref_clk);
    case (mode)
      0: begin
        {integer_exec_unit_a_done, integer_exec_unit_b_done, ls_tagchk, tag_bank_busy} <= 4'hf;
        fp_issue_cnt <= 2'h2;
        grad_insn_cnt <= 3'h3;
        grad_muldiv_cnt <= 3'h1;
      end
      1: grad_load_cnt <= 3'h4;
      2: grad_store <= 1'b1;
      3: {integer_exec_unit_a_done, float_exec_unit_b_done} <= 2'h3;
      default: begin
        misc_event <= 32'h0040_0020;
        grad_fp_cnt <= 3'h4;
      end
    endcase
    repeat (mode == 3 ? 2 : 1) @(posedge ref_clk);
    quiet();
    tick(2);
    if (n != 3'h0) begin
      {go, store_op, n_ops} <= {1'b1, st, n};
      @(posedge ref_clk) go <= 1'b0;
    end
    tick(8);
    rd(SEL_CNT0, v); chk("cnt0", e0, v);
    rd(SEL_CNT1, v); chk("cnt1", e1, v);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Run limit
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {rst_n, sr_wr, sr_rd, sr_sel, sr_wdata} = 37'h0;
    quiet();
    tick(8);
    rst_n <= 1'b1;
    t_reset();
    t_cycles();
    t_trap();
    t_refuse();
    t_tag();
    t_mht();
    t_events(32'h1, 32'h11, 0, 3'h1, 1'b0, 32'h6, 32'h4);
    t_events(32'h2, 32'h12, 1, 3'h3, 1'b0, 32'h3, 32'h4);
    t_events(32'h3, 32'h13, 2, 3'h2, 1'b1, 32'h2, 32'h1);
    t_events(32'he, 32'h11, 3, 3'h0, 1'b0, 32'h2, 32'h0);
    t_events(32'h5, 32'h15, 4, 3'h0, 1'b0, 32'h1, 32'h4);
    t_events(32'hf, 32'h11, 0, 3'h0, 1'b0, 32'h4, 32'h4);
    t_events(32'h5, 32'h16, 4, 3'h0, 1'b0, 32'h1, 32'h1);
    summarize();
  end
endmodule // cpu_perf_event_counters_bench
